/* hw/lssc_pkg.sv */
// Constants and carrier types of the low-side switch control block
package lssc_pkg;

	// ------------------------------------------------------------
	// Clock and times
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 125;
	localparam int SHORT_DETECT_NS = 10000;
	localparam int RETRY_OFF_NS    = 20000;
	localparam int MODE_NS         = 10000;
	localparam int POR_NS          = 40000;
	// Least times, rounded up to whole cycles
	localparam int SHORT_CYC   = (SHORT_DETECT_NS * CLK_MHZ + 999) / 1000;
	localparam int RETRY_CYC   = (RETRY_OFF_NS * CLK_MHZ + 999) / 1000;
	localparam int MODE_CYC    = (MODE_NS * CLK_MHZ + 999) / 1000;
	localparam int POR_CYC_DEF = (POR_NS * CLK_MHZ + 999) / 1000;
	localparam logic [11:0] SHORT_LAST = 12'(SHORT_CYC - 1);
	localparam logic [11:0] RETRY_LOAD = 12'(RETRY_CYC);
	localparam logic [11:0] MODE_LAST  = 12'(MODE_CYC - 1);
	localparam logic [11:0] CNT_ZERO   = 12'h000;
	localparam logic [11:0] CNT_ONE    = 12'h001;
	localparam logic [15:0] POR_ZERO   = 16'h0000;
	localparam logic [15:0] POR_ONE    = 16'h0001;

	// ------------------------------------------------------------
	// Serial word layout and reset values
	// ------------------------------------------------------------
	localparam int          NUM_OUT   = 6;
	localparam int          SLEEP_BIT = 7;
	localparam logic [7:0]  CMD_RST   = 8'h80;
	localparam logic [7:0]  WORD_ZERO = 8'h00;
	localparam logic [5:0]  OUT_OFF   = 6'h00;
	localparam logic [1:0]  TX_PAD    = 2'h0;
	localparam logic [3:0]  BIT_ZERO  = 4'h0;
	localparam logic [3:0]  BIT_ONE   = 4'h1;
	localparam logic [3:0]  BIT_TOP   = 4'h7;
	localparam logic [3:0]  BIT_FULL  = 4'h8;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       ovSense;
		logic       modeMid;
		logic [5:0] curLim;
		logic [5:0] aboveThr;
	} lssc_sense_t;

	typedef struct packed {
		logic        csN;
		logic        enableN;
		logic [2:0]  par;
		lssc_sense_t sense;
	} lssc_pins_t;

	localparam int PIN_W = $bits(lssc_pins_t);
	localparam logic [18:0] PIN_RST = 19'h40000;

	typedef enum logic [1:0] {
		PW_DEAD  = 2'b00,
		PW_RUN   = 2'b01,
		PW_SLEEP = 2'b10
	} lssc_pwr_t;

endpackage : lssc_pkg

/* hw/lssc_switch_ctrl.sv */
// Six-channel low-side switch control with serial command port
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE1] Current-limited on output: off, wait, retry
// [RULE2] Off output below threshold flags open load
// [RULE3] Both fault kinds latch into response
// [RULE4] Enable high, bit7 set: pull-downs off
// [RULE5] Hex: outputs 0-2 are serial OR parallel
// [RULE6] Hex: outputs 3-5 follow serial only
// [RULE7] Dual: 0,4,5 on by par0 or all
// [RULE8] Dual: 1,2,3 on by par1 or all
// [RULE9] Parallel ignored when enable high, bit7 set
// [RULE10] Mid mode level over 10 us: dual
// [RULE11] Overvoltage holds every output off
// [RULE12] Sample rising, shift falling while selected
// [RULE13] Deselected: no transfer, output high impedance
// [RULE14] Bit 7 first, chain after eighth edge
// [RULE15] Select rise takes new command word
// [RULE16] Select rise clears latched faults
// [RULE17] Power-up or wake: 40 us dead time
// [RULE18] Enable fall outside sleep: no dead time
// [RULE19] Bit7 with enable high: sleep, clear all
// [RULE20] Host holds enable low for operation
// [RULE21] Command powers up with sleep bit set
// [RULE22] Enable high, bit7 clear: parallel only
// [RULE23] Fault bits sit at output positions
module lssc_switch_ctrl
	import lssc_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYC_DEF
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        csN,
	input  wire logic        serIn,
	output logic             serOut,
	output logic             serOeN,
	input  wire logic        parInZero,
	input  wire logic        parInOne,
	input  wire logic        parInTwoModeSel,
	input  wire logic        enableN,
	input  wire lssc_sense_t sense,
	output logic [5:0]       switchOutputs,
	output logic             pullDownOff,
	output logic             dualMode,
	output logic             sleepActive
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

	lssc_pins_t       pinRaw;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic [PIN_W-1:0] sync3_q;
	logic [PIN_W-1:0] pinAgree;
	lssc_pins_t       pin_q;
	lssc_pins_t       pin_d;
	logic             csPrev_q;
	logic             csRise;
	logic             enHigh;
	logic             sleepReq;
	lssc_pwr_t        pwr_q;
	lssc_pwr_t        pwr_d;
	logic [15:0]      porCnt_q;
	logic [15:0]      porCnt_d;
	logic [7:0]       cmd_q;
	logic [7:0]       cmd_d;
	logic [7:0]       txWord_q;
	logic [5:0]       fault_q;
	logic [11:0]      modeCnt_q;
	logic [11:0]      modeCnt_d;
	logic             dual_d;
	logic [5:0]       ser;
	logic [2:0]       par;
	logic             grpA;
	logic             grpB;
	logic [5:0]       hexWant;
	logic [5:0]       dualWant;
	logic [5:0]       want;
	logic [5:0]       retryBusy;
	logic [5:0]       drive_d;
	logic             gateOn;
	logic             detEn;
	logic [7:0]       rxShift_q;
	logic [3:0]       bitCnt_q;
	logic [3:0]       bitNext;
	logic [2:0]       txIdx;
	logic             soBit_q;
	logic             soNext;

	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	assign pinRaw = {csN, enableN, {parInTwoModeSel, parInOne, parInZero}, sense};

	// Three stages; a bit moves only once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_q <= PIN_RST;
			sync2_q <= PIN_RST;
			sync3_q <= PIN_RST;
			pin_q   <= PIN_RST;
		end
		else
		begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= pin_d;
		end
	end

	// Per-bit hold while the late stages disagree
	assign pinAgree = ~(sync2_q ^ sync3_q);
	assign pin_d    = (pinAgree & sync2_q) | (~pinAgree & pin_q);

	// ------------------------------------------------------------
	// Frame edge and enable decode
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			csPrev_q <= 1'h1;
		else
			csPrev_q <= pin_q.csN;
	end

	assign csRise   = pin_q.csN & ~csPrev_q;
	assign enHigh   = pin_q.enableN;
	// Level form: once asleep the command is cleared, so it fires once
	assign sleepReq = enHigh & cmd_q[SLEEP_BIT];

	// ------------------------------------------------------------
	// Power state: dead time, run, sleep
	// ------------------------------------------------------------
	always_comb
	begin
		pwr_d    = pwr_q;
		porCnt_d = POR_ZERO;
		case (pwr_q)
			PW_DEAD:
			begin
				porCnt_d = porCnt_q + POR_ONE;
				if (sleepReq)
					pwr_d = PW_SLEEP;                   // [RULE19]
				else if (porCnt_q == POR_LAST)
					pwr_d = PW_RUN;                     // [RULE17]
			end
			PW_RUN:
			begin
				// Enable falling here leaves the state alone
				if (sleepReq)
					pwr_d = PW_SLEEP;                   // [RULE19] [RULE18]
			end
			PW_SLEEP:
			begin
				if (!enHigh)
					pwr_d = PW_DEAD;                    // [RULE17]
			end
			default:
				pwr_d = PW_DEAD;
		endcase
	end

	// Power-up starts in the dead interval
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pwr_q    <= PW_DEAD;                        // [RULE17]
			porCnt_q <= POR_ZERO;
		end
		else
		begin
			pwr_q    <= pwr_d;
			porCnt_q <= porCnt_d;
		end
	end

	// ------------------------------------------------------------
	// Command word
	// ------------------------------------------------------------
	// Shift register is stable here: no clock counts while deselected
	assign cmd_d = (pwr_q == PW_SLEEP) ? WORD_ZERO :      // [RULE19]
	               csRise ? rxShift_q : cmd_q;           // [RULE15]

	always_ff @(posedge clk)
	begin
		if (rst)
			cmd_q <= CMD_RST;                           // [RULE21]
		else
			cmd_q <= cmd_d;
	end

	// ------------------------------------------------------------
	// Mode detection on the mode-select comparator
	// ------------------------------------------------------------
	assign modeCnt_d = !pin_q.sense.modeMid ? CNT_ZERO :
	                   (modeCnt_q == MODE_LAST) ? modeCnt_q : modeCnt_q + CNT_ONE;
	// Losing the mid level drops straight back to hex
	assign dual_d    = pin_q.sense.modeMid & (dualMode | (modeCnt_q == MODE_LAST));

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			modeCnt_q <= CNT_ZERO;
			dualMode  <= 1'h0;
		end
		else
		begin
			modeCnt_q <= modeCnt_d;
			dualMode  <= dual_d;                        // [RULE10]
		end
	end

	// ------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------
	assign ser      = enHigh ? OUT_OFF : cmd_q[5:0];          // [RULE22]
	assign par      = sleepReq ? 3'h0 : pin_q.par;            // [RULE9]
	assign hexWant  = {ser[5:3], ser[2:0] | par};             // [RULE5] [RULE6]
	assign grpA     = par[0] | (ser[0] & ser[4] & ser[5]);    // [RULE7]
	assign grpB     = par[1] | (&ser[3:1]);                   // [RULE8]
	assign dualWant = {grpA, grpA, grpB, grpB, grpB, grpA};   // [RULE7] [RULE8]
	assign want     = dualMode ? dualWant : hexWant;

	// Off during dead time, sleep, overvoltage and per-channel retry
	assign gateOn  = (pwr_q == PW_RUN) & ~pin_q.sense.ovSense; // [RULE11] [RULE17]
	assign drive_d = want & {NUM_OUT{gateOn}} & ~retryBusy;    // [RULE1]
	assign detEn   = (pwr_q == PW_RUN);                       // [RULE19]

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			switchOutputs <= OUT_OFF;
			pullDownOff   <= 1'h0;
			sleepActive   <= 1'h0;
		end
		else
		begin
			switchOutputs <= drive_d;
			pullDownOff   <= sleepReq | (pwr_q == PW_SLEEP); // [RULE4] held through sleep
			sleepActive   <= (pwr_q == PW_SLEEP);
		end
	end

	// ------------------------------------------------------------
	// Per-channel fault detection and retry
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_OUT; i++)
	begin : g_chan
		logic [11:0] detCnt_q;
		logic [11:0] retryCnt_q;
		logic        shortCond;
		logic        openCond;
		logic        cond;
		logic        hit;

		assign shortCond = switchOutputs[i] & pin_q.sense.curLim[i] &
		                   pin_q.sense.aboveThr[i];                     // [RULE1]
		// No open check while parked for retry: the load is still shorted
		assign openCond  = ~switchOutputs[i] & ~pin_q.sense.aboveThr[i] &
		                   ~retryBusy[i];                               // [RULE2]
		assign cond      = detEn & (shortCond | openCond);
		assign hit       = cond & (detCnt_q == SHORT_LAST);
		assign retryBusy[i] = (retryCnt_q != CNT_ZERO);

		// Restarts after each hit so a lasting fault is caught again
		always_ff @(posedge clk)
		begin
			if (rst || !cond || hit)
				detCnt_q <= CNT_ZERO;
			else
				detCnt_q <= detCnt_q + CNT_ONE;
		end

		// Off time after a short, then the output retries
		always_ff @(posedge clk)
		begin
			if (rst || !detEn)
				retryCnt_q <= CNT_ZERO;
			else if (hit && shortCond)
				retryCnt_q <= RETRY_LOAD;                   // [RULE1]
			else if (retryBusy[i])
				retryCnt_q <= retryCnt_q - CNT_ONE;
		end

		// Set wins over the frame-end clear
		always_ff @(posedge clk)
		begin
			if (rst || pwr_q == PW_SLEEP)
				fault_q[i] <= 1'h0;                         // [RULE19]
			else if (hit)
				fault_q[i] <= 1'h1;                         // [RULE3] [RULE23]
			else if (csRise)
				fault_q[i] <= 1'h0;                         // [RULE16]
		end
	end

	// ------------------------------------------------------------
	// Response snapshot and output enable
	// ------------------------------------------------------------
	// Frozen while selected so the serial side reads a steady word
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txWord_q <= WORD_ZERO;
			serOeN   <= 1'h1;
		end
		else
		begin
			if (pin_q.csN)
				txWord_q <= {TX_PAD, fault_q};              // [RULE23]
			serOeN <= pin_q.csN;                            // [RULE13]
		end
	end

	// ------------------------------------------------------------
	// Serial clock domain
	// ------------------------------------------------------------
	// Receive on rising edges only while selected
	always_ff @(posedge sclk)
	begin
		if (!csN)
			rxShift_q <= {rxShift_q[6:0], serIn};          // [RULE12] [RULE13]
	end

	// Falling-edge count; deselect clears it without a clock
	assign bitNext = (bitCnt_q == BIT_FULL) ? bitCnt_q : bitCnt_q + BIT_ONE;
	assign txIdx   = 3'(BIT_TOP - bitNext);
	// From the eighth edge on the chain data comes through
	assign soNext  = (bitNext == BIT_FULL) ? rxShift_q[7] : txWord_q[txIdx]; // [RULE14]

	always_ff @(negedge sclk or posedge csN)
	begin
		if (csN)
		begin
			bitCnt_q <= BIT_ZERO;                           // [RULE13]
			soBit_q  <= 1'h0;
		end
		else
		begin
			bitCnt_q <= bitNext;                            // [RULE12]
			soBit_q  <= soNext;
		end
	end

	// Bit 7 must show before any clock edge, hence the select mux
	assign serOut = (bitCnt_q == BIT_ZERO) ? txWord_q[SLEEP_BIT] : soBit_q; // [RULE14]

endmodule : lssc_switch_ctrl

`default_nettype wire

/* verif/lssc_switch_ctrl_assertions.sv */
// Port checker for the switch control block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module lssc_checker
	import lssc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sclk,
	input wire logic        csN,
	input wire logic        serIn,
	input wire logic        serOut,
	input wire logic        serOeN,
	input wire logic        enableN,
	input wire lssc_sense_t sense,
	input wire logic [5:0]  switchOutputs,
	input wire logic        pullDownOff,
	input wire logic        dualMode,
	input wire logic        sleepActive
);
	// ----------
	// Helpers
	// ----------
	localparam int MID_WAIT = MODE_CYC + 8;
	logic [11:0] midCnt_q;
	logic [3:0]  fallCnt_q;
	logic [7:0]  rxHist_q;
	// Mid-level run length, saturating so it never wraps
	always_ff @(posedge clk)
		if (rst || !sense.modeMid) midCnt_q <= 12'h000;
		else if (midCnt_q != 12'hFFF) midCnt_q <= midCnt_q + 12'h001;
	// Falling edges in a frame; select high clears
	always_ff @(negedge sclk or posedge csN)
		if (csN) fallCnt_q <= 4'h0;
		else if (fallCnt_q != 4'hF) fallCnt_q <= fallCnt_q + 4'h1;
	// Bits taken in, oldest at the top
	always_ff @(posedge sclk)
		if (!csN) rxHist_q <= {rxHist_q[6:0], serIn};
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_ovHeld; sense.ovSense [*8]; endsequence
	sequence s_enHex; (enableN && !dualMode) [*8]; endsequence
	property p_ovOff; s_ovHeld |-> switchOutputs == OUT_OFF; endproperty
	a_ovOff: assert property (p_ovOff) else $error("outputs on in overvoltage");
	property p_sleepOff; sleepActive [*2] |-> switchOutputs == OUT_OFF; endproperty
	a_sleepOff: assert property (p_sleepOff) else $error("outputs on in sleep");
	property p_deselHiZ; csN [*8] |-> serOeN; endproperty
	a_deselHiZ: assert property (p_deselHiZ) else $error("driving while deselected");
	property p_selDrive; (!csN) [*8] |-> !serOeN; endproperty
	a_selDrive: assert property (p_selDrive) else $error("not driving when selected");
	property p_pdOn; (!enableN) [*8] |-> !pullDownOff; endproperty
	a_pdOn: assert property (p_pdOn) else $error("pull-downs off while enabled");
	property p_modeHex; (!sense.modeMid) [*6] |-> !dualMode; endproperty
	a_modeHex: assert property (p_modeHex) else $error("dual without mid level");
	property p_modeDual; midCnt_q >= 12'(MID_WAIT) |-> dualMode; endproperty
	a_modeDual: assert property (p_modeDual) else $error("dual not taken");
	property p_hexHigh; s_enHex |-> switchOutputs[5:3] == 3'h0; endproperty
	a_hexHigh: assert property (p_hexHigh) else $error("upper outputs on");
	property p_chain;
		@(posedge sclk) disable iff (csN) fallCnt_q >= 4'h8 |-> serOut == rxHist_q[7];
	endproperty
	a_chain: assert property (p_chain) else $error("chained bit wrong");
endmodule : lssc_checker

bind lssc_switch_ctrl lssc_checker u_chk (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
	.serIn(serIn), .serOut(serOut), .serOeN(serOeN), .enableN(enableN), .sense(sense),
	.switchOutputs(switchOutputs), .pullDownOff(pullDownOff), .dualMode(dualMode),
	.sleepActive(sleepActive));
`default_nettype wire

/* verif/lssc_spi_host.sv */
// Serial host model framing transfers to the switch control
`timescale 1ns/1ps
`default_nettype none
module lssc_spi_host
(
	output logic      sclk,
	output logic      csN,
	output logic      serIn,
	input  wire logic serOut
);
	// Idle: deselected, clock parked, data at its pull-down level
	initial
	begin
		sclk = 1'h0;
		csN = 1'h1;
		serIn = 1'h0;
	end
	// n bits msb first; the 15 ns clock runs only inside a frame
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		csN = 1'h0;
		#120;
		for (int i = n - 1; i >= 0; i--)
		begin
			serIn = tx[i];
			#7.5 sclk = 1'h1;
			rx[i] = serOut;
			#7.5 sclk = 1'h0;
		end
		#10 csN = 1'h1;
		serIn = 1'h0;
		#60; // Gap long enough for the system clock to see it
	endtask : xfer
endmodule : lssc_spi_host
`default_nettype wire

/* verif/lssc_switch_ctrl_tb.sv */
// Self-checking bench for the switch control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
	begin \
		compares++; \
		if ((gt) !== (ex)) \
		begin \
			numErrors++; \
			$display("unexpected %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module lssc_switch_ctrl_tb
	import lssc_pkg::*;
;
	logic        clk, rst, sclk, csN, serIn, serOut, serOeN;
	logic        parInZero, parInOne, parInTwoModeSel, enableN;
	logic        pullDownOff, dualMode, sleepActive;
	logic [5:0]  switchOutputs;
	logic [15:0] rx;
	lssc_sense_t sense;
	int          numErrors, compares;
	// 125 MHz system clock
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	lssc_switch_ctrl #(.POR_CYCLES(20)) DUT (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
		.serIn(serIn), .serOut(serOut), .serOeN(serOeN), .parInZero(parInZero),
		.parInOne(parInOne), .parInTwoModeSel(parInTwoModeSel), .enableN(enableN),
		.sense(sense), .switchOutputs(switchOutputs), .pullDownOff(pullDownOff),
		.dualMode(dualMode), .sleepActive(sleepActive));
	lssc_spi_host host (.sclk(sclk), .csN(csN), .serIn(serIn), .serOut(serOut));
	// ----------
	// Helpers
	// ----------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic send(input logic [7:0] cmd);
		host.xfer({8'h00, cmd}, 8, rx);
		cyc(8);
	endtask : send
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// ----------
	// Scenarios
	// ----------
	task automatic t_wake;
		`CHK("sleep at power-up", 1'h1, sleepActive)
		enableN = 1'h0;
		parInZero = 1'h1;
		cyc(10);
		`CHK("dead time outputs", 6'h00, switchOutputs)
		cyc(30);
		`CHK("outputs after wake", 6'h01, switchOutputs)
		parInZero = 1'h0;
		$display("wake test done");
	endtask : t_wake
	task automatic t_hex;
		send(8'h38);
		`CHK("serial upper outputs", 6'h38, switchOutputs)
		`CHK("clean response", 8'h00, rx[7:0])
		for (int i = 0; i < 3; i++)
		begin
			{parInTwoModeSel, parInOne, parInZero} = 3'(1 << i);
			cyc(8);
			`CHK("parallel or serial", 6'h38 | 6'(1 << i), switchOutputs)
		end
		{parInTwoModeSel, parInOne, parInZero} = 3'h0;
		host.xfer(16'h5A02, 16, rx);
		cyc(8);
		`CHK("chained byte", 8'h5A, rx[7:0])
		`CHK("last byte taken", 6'h02, switchOutputs)
		$display("hex test done");
	endtask : t_hex
	task automatic t_dual;
		sense.modeMid = 1'h1;
		cyc(MODE_CYC + 10);
		`CHK("dual grouping", 1'h1, dualMode)
		send(8'h31);
		`CHK("serial group a", 6'h31, switchOutputs)
		send(8'h0C);
		`CHK("partial group b", 6'h00, switchOutputs)
		parInOne = 1'h1;
		cyc(8);
		`CHK("parallel group b", 6'h0E, switchOutputs)
		parInOne = 1'h0;
		parInZero = 1'h1;
		send(8'h0E);
		`CHK("both groups", 6'h3F, switchOutputs)
		parInZero = 1'h0;
		sense.modeMid = 1'h0;
		cyc(8);
		`CHK("hex again", 1'h0, dualMode)
		$display("dual test done");
	endtask : t_dual
	task automatic t_ov;
		send(8'h3F);
		sense.ovSense = 1'h1;
		cyc(8);
		`CHK("overvoltage off", 6'h00, switchOutputs)
		sense.ovSense = 1'h0;
		cyc(8);
		`CHK("overvoltage over", 6'h3F, switchOutputs)
		$display("overvoltage test done");
	endtask : t_ov
	task automatic t_fault;
		send(8'h01);
		sense.curLim = 6'h01;
		sense.aboveThr = 6'h1F;
		cyc(SHORT_CYC + 10);
		`CHK("short turns off", 1'h0, switchOutputs[0])
		sense.curLim = 6'h00;
		sense.aboveThr = 6'h3F;
		send(8'h01);
		`CHK("latched faults", 8'h21, rx[7:0])
		`CHK("open load bit", 1'h1, rx[5])
		cyc(RETRY_CYC);
		`CHK("retry on", 6'h01, switchOutputs)
		send(8'h01);
		`CHK("faults cleared", 8'h00, rx[7:0])
		$display("fault test done");
	endtask : t_fault
	task automatic t_sleep;
		send(8'h3F);
		enableN = 1'h1;
		parInOne = 1'h1;
		cyc(8);
		`CHK("parallel only", 6'h02, switchOutputs)
		`CHK("pull-downs kept", 1'h0, pullDownOff)
		enableN = 1'h0;
		cyc(8);
		`CHK("no dead time", 6'h3F, switchOutputs)
		send(8'hBF);
		enableN = 1'h1;
		cyc(8);
		`CHK("asleep", 1'h1, sleepActive)
		`CHK("pull-downs off", 1'h1, pullDownOff)
		`CHK("parallel ignored", 6'h00, switchOutputs)
		send(8'h3F);
		`CHK("sleep response", 8'h00, rx[7:0])
		enableN = 1'h0;
		cyc(40);
		`CHK("command cleared", 6'h02, switchOutputs)
		$display("sleep test done");
	endtask : t_sleep
	// Main sequence
	initial
	begin
		numErrors = 0;
		compares = 0;
		rst = 1'h1;
		enableN = 1'h1;
		{parInTwoModeSel, parInOne, parInZero} = 3'h0;
		sense = {1'h0, 1'h0, 6'h00, 6'h3F};
		repeat (8) @(posedge clk);
		#1 rst = 1'h0;
		cyc(30);
		t_wake;
		t_hex;
		t_dual;
		t_ov;
		t_fault;
		t_sleep;
		report_and_stop;
	end
	// Watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge clk);
		numErrors++;
		report_and_stop;
	end
endmodule : lssc_switch_ctrl_tb
`default_nettype wire
